// *** csa_attr_dword.sv ***
// One configuration dword with per-bit access attributes
`timescale 1ns/100ps

module csa_attr_dword #(
  parameter logic [31:0] RO_MASK  = 32'h0000_0000,
  parameter logic [31:0] RW_MASK  = 32'h0000_0000,
  parameter logic [31:0] W1C_MASK = 32'h0000_0000,
  parameter logic [31:0] WO_MASK  = 32'h0000_0000,
  parameter logic [31:0] LK_MASK  = 32'h0000_0000,
  parameter logic [31:0] SET_MASK = 32'h0000_0000
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [31:0] rst_value,
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_be,
  input  wire logic [31:0] wr_data,
  input  wire logic [31:0] hw_set,
  output logic      [31:0] value
);

  // ==========================================================================
  // Per-bit storage
  logic [31:0] written;
  logic        locked;

  assign locked = value[csa_pkg::LOCK_POS] & SET_MASK[csa_pkg::LOCK_POS];

  for (genvar i = 0; i < 32; i++) begin : g_bit
    logic wr_bit;
    assign wr_bit = wr_en & wr_be[i/8];

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        value[i] <= rst_value[i] & (RO_MASK[i] | RW_MASK[i] | W1C_MASK[i] |
                                    WO_MASK[i] | LK_MASK[i] | SET_MASK[i]);
      end else if (W1C_MASK[i]) begin
        if (hw_set[i]) begin
          value[i] <= 1'b1;             // Event beats a clear in the same cycle
        end else if (wr_bit && wr_data[i]) begin
          value[i] <= 1'b0;
        end
      end else if (RW_MASK[i]) begin
        if (wr_bit) begin
          value[i] <= wr_data[i];
        end
      end else if (WO_MASK[i]) begin
        if (wr_bit && !written[i]) begin
          value[i] <= wr_data[i];
        end
      end else if (LK_MASK[i]) begin
        if (wr_bit && !locked) begin
          value[i] <= wr_data[i];
        end
      end else if (SET_MASK[i]) begin
        if (wr_bit && wr_data[i]) begin
          value[i] <= 1'b1;
        end
      end
      // Read-only and reserved bits simply hold
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        written[i] <= 1'b0;
      end else if (WO_MASK[i] && wr_bit) begin
        written[i] <= 1'b1;
      end
    end
  end

endmodule : csa_attr_dword

// *** csa_config_space.sv ***
// Configuration space decode and attribute register bank of the hub
`timescale 1ns/100ps

module csa_config_space #(
  parameter logic [31:0] HOST_ID_WORD = 32'h0001_0001, // Arbitrary identity value
  parameter logic [31:0] GFX_ID_WORD  = 32'h0002_0001  // Arbitrary identity value
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Configuration access port
  input  wire logic        cfg_req,
  input  wire logic        cfg_write,
  input  wire logic [7:0]  cfg_bus,
  input  wire logic [4:0]  cfg_dev,
  input  wire logic [2:0]  cfg_fn,
  input  wire logic [5:0]  cfg_idx,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic             cfg_ack,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_claim,
  output logic             cfg_fwd_type0,
  output logic             cfg_fwd_type1,
  // Straps and hardware events
  input  wire logic        strap_native_gfx,
  input  wire logic [7:0]  strap_mem_cfg,
  input  wire logic [15:0] status_event,
  // Register-driven controls
  output logic             native_gfx_mode,
  output logic      [7:0]  vga_ctrl,
  output logic      [15:0] host_cmd
);

  // ==========================================================================
  // Strap synchronisers
  localparam int SW = csa_pkg::STRAP_W + 1;

  logic [SW-1:0] strap_s1;
  logic [SW-1:0] strap_s2;
  logic [SW-1:0] strap_s3;
  logic [SW-1:0] strap_q;

  // No reset here: the straps must be sampled while the block is held in reset
  always_ff @(posedge clk) begin
    strap_s1 <= {strap_native_gfx, strap_mem_cfg};
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
  end

  // Accept a strap level only once two stages agree, filtering a late edge
  always_ff @(posedge clk) begin
    if (strap_s2 == strap_s3) begin
      strap_q <= strap_s3;
    end
  end

  // ==========================================================================
  // Reset values
  logic [csa_pkg::NUM_REGS-1:0][31:0] rst_value;

  always_comb begin
    rst_value = csa_pkg::RST_VAL;
    rst_value[csa_pkg::REG_HOST_ID] = HOST_ID_WORD;
    rst_value[csa_pkg::REG_GFX_ID]  = GFX_ID_WORD;
    rst_value[csa_pkg::REG_MEM_CFG][csa_pkg::STRAP_W-1:0] =
      strap_q[csa_pkg::STRAP_W-1:0];
  end

  // Native graphics mode is latched from the strap during reset
  logic native_mode;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      native_mode <= strap_q[SW-1];
    end
  end

  // ==========================================================================
  // Address decode
  logic                         root_bus;
  logic                         dev_present;
  logic [csa_pkg::NUM_REGS-1:0] reg_hit;
  logic                         any_hit;

  assign root_bus = (cfg_bus == csa_pkg::CFG_BUS_ROOT);

  always_comb begin
    dev_present = 1'b0;
    if (root_bus && cfg_dev == csa_pkg::DEV_HOST) begin
      dev_present = (cfg_fn == csa_pkg::FN_LEGACY) ||
                    (cfg_fn == csa_pkg::FN_MEMIF)  ||
                    (cfg_fn == csa_pkg::FN_VENDOR);
    end else if (root_bus && cfg_dev == csa_pkg::DEV_GFX) begin
      dev_present = (cfg_fn == csa_pkg::FN_GFX);
    end
  end

  for (genvar r = 0; r < csa_pkg::NUM_REGS; r++) begin : g_dec
    logic gated;
    // Legacy graphics dword vanishes into reserved space without the strap
    assign gated = (r == csa_pkg::REG_VGA_CTRL) ? native_mode : 1'b1;
    assign reg_hit[r] = dev_present && gated &&
                        cfg_dev == csa_pkg::REG_DEV[r] &&
                        cfg_fn  == csa_pkg::REG_FN[r]  &&
                        cfg_idx == csa_pkg::REG_IDX[r];
  end

  assign any_hit = |reg_hit;

  // ==========================================================================
  // Register bank
  logic [csa_pkg::NUM_REGS-1:0][31:0] reg_value;
  logic [csa_pkg::NUM_REGS-1:0][31:0] hw_set;

  always_comb begin
    hw_set = '0;
    hw_set[csa_pkg::REG_HOST_CMD][31:16] = status_event;
  end

  for (genvar r = 0; r < csa_pkg::NUM_REGS; r++) begin : g_reg
    csa_attr_dword #(
      .RO_MASK  (csa_pkg::RO_MASK[r]),
      .RW_MASK  (csa_pkg::RW_MASK[r]),
      .W1C_MASK (csa_pkg::W1C_MASK[r]),
      .WO_MASK  (csa_pkg::WO_MASK[r]),
      .LK_MASK  (csa_pkg::LK_MASK[r]),
      .SET_MASK (csa_pkg::SET_MASK[r])
    ) u_dword (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .rst_value (rst_value[r]),
      .wr_en     (cfg_req && cfg_write && reg_hit[r]),
      .wr_be     (cfg_be),
      .wr_data   (cfg_wdata),
      .hw_set    (hw_set[r]),
      .value     (reg_value[r])
    );
  end

  // ==========================================================================
  // Read data mux
  logic [31:0] hit_word;
  logic [31:0] read_word;

  always_comb begin
    hit_word = 32'h0000_0000;
    for (int r = 0; r < csa_pkg::NUM_REGS; r++) begin
      if (reg_hit[r]) begin
        hit_word = reg_value[r];
      end
    end
  end

  // Reserved offsets inside a present function still answer, with a fixed word
  assign read_word = any_hit ? hit_word : csa_pkg::RSVD_RDATA;

  // ==========================================================================
  // Completion
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= cfg_req;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (cfg_req && !cfg_write) begin
      cfg_rdata <= read_word;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_claim <= 1'b0;
    end else begin
      cfg_claim <= cfg_req && dev_present;
    end
  end

  // Unclaimed root bus cycles go down the hub link untranslated
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_fwd_type0 <= 1'b0;
    end else begin
      cfg_fwd_type0 <= cfg_req && root_bus && !dev_present;
    end
  end

  // Nonzero bus numbers belong to bridges further down
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_fwd_type1 <= 1'b0;
    end else begin
      cfg_fwd_type1 <= cfg_req && !root_bus;
    end
  end

  // ==========================================================================
  // Register-driven controls
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      native_gfx_mode <= 1'b0;
    end else begin
      native_gfx_mode <= native_mode;
    end
  end

  // Forced quiet without the strap so a stale value cannot leak out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      vga_ctrl <= 8'h00;
    end else begin
      vga_ctrl <= native_mode ? reg_value[csa_pkg::REG_VGA_CTRL][7:0] : 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      host_cmd <= 16'h0000;
    end else begin
      host_cmd <= reg_value[csa_pkg::REG_HOST_CMD][15:0];
    end
  end

endmodule : csa_config_space

// *** csa_config_space_tb.sv ***
// Self-checking testbench for the configuration space block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module csa_config_space_tb;
  localparam logic [31:0] HID = 32'h5a5a_0101; // Arbitrary identity value
  localparam logic [31:0] GID = 32'h5a5a_0202; // Arbitrary identity value
  logic clk, sys_rst, cfg_req, cfg_write, cfg_ack, cfg_claim, t0, t1, sng, ngm, ok;
  logic [21:0] cfg_addr;
  logic [3:0]  cfg_be, be;
  logic [31:0] cfg_wdata, cfg_rdata, rd, v, ex;
  logic [7:0]  smc, vga_ctrl, b;
  logic [15:0] status_event, host_cmd;
  logic [2:0]  rt;
  int          err_total, comparisons;
  csa_config_space #(.HOST_ID_WORD(HID), .GFX_ID_WORD(GID)) dut (.clk(clk), .sys_rst(sys_rst),
    .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_bus(cfg_addr[21:14]),
    .cfg_dev(cfg_addr[13:9]), .cfg_fn(cfg_addr[8:6]), .cfg_idx(cfg_addr[5:0]), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_claim(cfg_claim),
    .cfg_fwd_type0(t0), .cfg_fwd_type1(t1), .strap_native_gfx(sng), .strap_mem_cfg(smc),
    .status_event(status_event), .native_gfx_mode(ngm), .vga_ctrl(vga_ctrl),
    .host_cmd(host_cmd));
  csa_host_model host (.clk(clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
    .route({cfg_claim, t0, t1}), .cfg_req(cfg_req), .cfg_write(cfg_write),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata));
  // ==========
  // Helpers
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [21:0] ad(input logic [4:0] d, input logic [2:0] f,
                                     input logic [5:0] i);
    return {8'h00, d, f, i};
  endfunction : ad
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] e);
    for (int k = 0; k < 4; k++) if (e[k]) o[8*k +: 8] = n[8*k +: 8];
    return o;
  endfunction : merge
  function automatic logic [2:0] exp_route(input logic [21:0] a);
    if (a[21:14] != 8'h00) return 3'b001;
    if ((a[13:9] == 5'h00 && a[8:6] inside {3'h0, 3'h1, 3'h3}) || a[13:6] == 8'h10) return 3'b100;
    return 3'b010;
  endfunction : exp_route
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic rw(input logic w, input logic [21:0] a, input logic [3:0] e,
                    input logic [31:0] d);
    host.access(w, a, e, d, rd, rt, ok);
    if (!ok) begin
      err_total++;
      $display("[ERR] ack expected 1 seen 0");
      give_verdict();
    end
  endtask : rw
  task automatic rdc(input string nm, input logic [21:0] a, input logic [31:0] e);
    rw(1'b0, a, 4'hf, 32'h0);
    `CHK(nm, e, rd)
  endtask : rdc
  // Straps settle well before release; six edges covers the filter
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask : do_reset
  // ==========
  // Scenarios
  initial begin
    {sys_rst, sng, status_event, err_total, comparisons} = {1'b1, 1'b1, 16'h0, 64'h0};
    void'($urandom(32'hdacb79dd));
    smc = 8'($urandom);
    do_reset();
    rdc("host id", ad(0, 0, 0), HID);
    rdc("gfx id", ad(2, 0, 0), GID);
    rdc("mem strap", ad(0, 1, 6'h18), {24'h0, smc});
    `CHK("native", 1'b1, ngm)
    $display("test defaults done");
    ex = 32'h0;
    for (int k = 0; k < 16; k++) begin
      v = $urandom;
      be = 4'($urandom);
      ex = merge(ex, v, be);
      rw(1'b1, ad(0, 3, 6'h10), be, v);
      rdc("vendor rw", ad(0, 3, 6'h10), ex);
    end
    rw(1'b1, ad(0, 0, 0), 4'hf, ~HID);
    rdc("host id ro", ad(0, 0, 0), HID);
    rw(1'b1, ad(2, 0, 6'h30), 4'h1, 32'hffff_ff99);
    rdc("vga rw", ad(2, 0, 6'h30), 32'h99);
    `CHK("vga ctrl", 8'h99, vga_ctrl)
    host.rmw(ad(2, 0, 1), 32'h0000_ffff, 32'h1234_beef, ok);
    `CHK("rmw ack", 1'b1, ok)
    rdc("gfx cmd", ad(2, 0, 1), 32'h0000_beef);
    $display("test rw done");
    v = {16'h0, 16'($urandom)};
    rw(1'b1, ad(0, 0, 1), 4'hf, v);
    // Control output follows the register one edge later
    @(posedge clk);
    `CHK("host cmd", v[15:0], host_cmd)
    status_event <= 16'ha5c3;
    @(posedge clk);
    status_event <= 16'h0;
    rdc("w1c set", ad(0, 0, 1), {16'ha5c3, v[15:0]});
    rw(1'b1, ad(0, 0, 1), 4'hc, 32'h8001_ffff);
    rdc("w1c clear", ad(0, 0, 1), {16'h25c2, v[15:0]});
    $display("test w1c done");
    rw(1'b1, ad(0, 0, 6'h14), 4'h1, 32'h3c);
    rw(1'b1, ad(0, 0, 6'h14), 4'h1, 32'hc3);
    rdc("once", ad(0, 0, 6'h14), 32'h3c);
    rw(1'b1, ad(0, 0, 6'h14), 4'h2, 32'h5a00);
    rw(1'b1, ad(0, 0, 6'h14), 4'h8, 32'h8000_0000);
    rw(1'b1, ad(0, 0, 6'h14), 4'h2, 32'ha500);
    rdc("locked", ad(0, 0, 6'h14), 32'h8000_5a3c);
    rw(1'b1, ad(0, 0, 6'h14), 4'hc, 32'h0055_0000);
    rdc("lock stays", ad(0, 0, 6'h14), 32'h8000_5a3c);
    $display("test once lock done");
    for (int k = 0; k < 3; k++) begin
      be = (k == 0) ? 4'h1 : (k == 1) ? 4'h3 : 4'hf;
      rw(1'b1, ad(0, 0, 6'h3f), be, $urandom);
      rdc("reserved", ad(0, 0, 6'h3f), 32'h0);
      `CHK("reserved claim", 3'b100, rt)
    end
    for (int k = 0; k < 32; k++) begin
      b = ($urandom % 4 == 0) ? 8'($urandom | 1) : 8'h00;
      ex = {b, 5'($urandom % 4), 3'($urandom), 6'($urandom)};
      rw(1'b0, ex[21:0], 4'hf, 32'h0);
      `CHK("route", exp_route(ex[21:0]), rt)
    end
    $display("test routing done");
    sng <= 1'b0;
    smc <= 8'($urandom);
    do_reset();
    rw(1'b1, ad(2, 0, 6'h30), 4'h1, 32'hff);
    rdc("vga absent", ad(2, 0, 6'h30), 32'h0);
    `CHK("native off", 1'b0, ngm)
    `CHK("vga off", 8'h00, vga_ctrl)
    rdc("mem strap 2", ad(0, 1, 6'h18), {24'h0, smc});
    rdc("vendor reset", ad(0, 3, 6'h10), 32'h0);
    rdc("prot reset", ad(0, 0, 6'h14), 32'h0);
    rw(1'b1, ad(0, 0, 6'h14), 4'h1, 32'h77);
    rdc("once again", ad(0, 0, 6'h14), 32'h77);
    $display("test second reset done");
    give_verdict();
  end
endmodule : csa_config_space_tb

// *** csa_host_model.sv ***
// Host model issuing configuration accesses
`timescale 1ns/100ps
module csa_host_model (
  input  wire logic        clk,
  input  wire logic        cfg_ack,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic [2:0]  route,
  output logic             cfg_req,
  output logic             cfg_write,
  output logic      [21:0] cfg_addr,
  output logic      [3:0]  cfg_be,
  output logic      [31:0] cfg_wdata
);
  // ==========
  // Access tasks
  initial {cfg_req, cfg_write, cfg_addr, cfg_be, cfg_wdata} = '0;
  // Request is a one-cycle pulse; address and data stay until ack
  task automatic access(input logic w, input logic [21:0] a, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic [2:0] rt, output logic ok);
    ok = 1'b0;
    @(posedge clk);
    cfg_req <= 1'b1;
    cfg_write <= w;
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= wd;
    @(posedge clk);
    cfg_req <= 1'b0;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge clk);
      ok = (cfg_ack === 1'b1);
    end
    rd = cfg_rdata;
    rt = route;
    // Stale data would hide a sampling slip
    cfg_wdata <= ~wd;
  endtask : access
  // Reserved bits kept by read, merge and write back
  task automatic rmw(input logic [21:0] a, input logic [31:0] m, input logic [31:0] v,
                     output logic ok);
    logic [31:0] rd;
    logic [2:0]  rt;
    logic        ok1;
    access(1'b0, a, 4'hf, 32'h0, rd, rt, ok1);
    access(1'b1, a, 4'hf, (rd & ~m) | (v & m), rd, rt, ok);
    ok = ok & ok1;
  endtask : rmw
endmodule : csa_host_model

// *** csa_monitor.sv ***
// Port checker for the configuration space block
`timescale 1ns/100ps
module csa_monitor #(
  parameter logic [31:0] HOST_ID_WORD = 32'h0001_0001
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        cfg_req,
  input wire logic        cfg_write,
  input wire logic [7:0]  cfg_bus,
  input wire logic [4:0]  cfg_dev,
  input wire logic [2:0]  cfg_fn,
  input wire logic [5:0]  cfg_idx,
  input wire logic        cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_claim,
  input wire logic        cfg_fwd_type0,
  input wire logic        cfg_fwd_type1,
  input wire logic        native_gfx_mode,
  input wire logic [7:0]  vga_ctrl
);
  // ==========
  // Answer timing and routing
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire r0 = cfg_req && (cfg_bus == 8'h00);
  a_ack_next: assert property (cfg_req |=> cfg_ack)
    else $error("ack missing after request");
  a_ack_only: assert property (!cfg_req |=> !cfg_ack)
    else $error("ack without request");
  a_one_route: assert property (cfg_ack |->
    $onehot({cfg_claim, cfg_fwd_type0, cfg_fwd_type1})) else $error("route not one-hot");
  a_route_idle: assert property (!cfg_ack |->
    !(cfg_claim || cfg_fwd_type0 || cfg_fwd_type1)) else $error("route flag without ack");
  a_far_type1: assert property (cfg_req && cfg_bus != 8'h00 |=> cfg_fwd_type1)
    else $error("nonzero bus not forwarded");
  a_host_claim: assert property (r0 && cfg_dev == 5'h00 &&
    cfg_fn inside {3'h0, 3'h1, 3'h3} |=> cfg_claim) else $error("host function not claimed");
  a_gfx_claim: assert property (r0 && cfg_dev == 5'h02 && cfg_fn == 3'h0 |=> cfg_claim)
    else $error("graphics not claimed");
  a_absent_fwd: assert property (r0 &&
    (cfg_dev == 5'h01 || (cfg_dev == 5'h00 && cfg_fn == 3'h2)) |=> cfg_fwd_type0)
    else $error("absent target not forwarded");
  a_rdata_hold: assert property (!(cfg_req && !cfg_write) |=> $stable(cfg_rdata))
    else $error("read data moved without read");
  a_id_ro: assert property (r0 && !cfg_write && {cfg_dev, cfg_fn, cfg_idx} == 14'h0
    |=> cfg_rdata == HOST_ID_WORD) else $error("host identity wrong");
  a_vga_gate: assert property (!native_gfx_mode |-> vga_ctrl == 8'h00)
    else $error("vga control live without strap");
endmodule : csa_monitor
bind csa_config_space csa_monitor #(.HOST_ID_WORD(HOST_ID_WORD)) u_mon (
  .clk(clk), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_write(cfg_write),
  .cfg_bus(cfg_bus), .cfg_dev(cfg_dev), .cfg_fn(cfg_fn), .cfg_idx(cfg_idx),
  .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .cfg_claim(cfg_claim),
  .cfg_fwd_type0(cfg_fwd_type0), .cfg_fwd_type1(cfg_fwd_type1),
  .native_gfx_mode(native_gfx_mode), .vga_ctrl(vga_ctrl));

// *** csa_pkg.sv ***
// Constants and register table for the configuration space attribute logic
package csa_pkg;

  // ==========================================================================
  // Logical bus, device and function numbers
  localparam logic [7:0] CFG_BUS_ROOT  = 8'h00;
  localparam logic [4:0] DEV_HOST      = 5'h00;
  localparam logic [4:0] DEV_GFX       = 5'h02;
  localparam logic [2:0] FN_LEGACY     = 3'h0;
  localparam logic [2:0] FN_MEMIF      = 3'h1;
  localparam logic [2:0] FN_VENDOR     = 3'h3;
  localparam logic [2:0] FN_GFX        = 3'h0;

  // ==========================================================================
  // Register table, one entry per implemented dword
  localparam int NUM_REGS = 8;
  localparam int REG_HOST_ID   = 0;
  localparam int REG_HOST_CMD  = 1;
  localparam int REG_PROTECT   = 2;
  localparam int REG_MEM_CFG   = 3;
  localparam int REG_VENDOR    = 4;
  localparam int REG_GFX_ID    = 5;
  localparam int REG_GFX_CMD   = 6;
  localparam int REG_VGA_CTRL  = 7;

  // Bit that locks the lockable field of the protect register
  localparam int LOCK_POS = 31;
  // Strap-loaded field of the memory configuration register
  localparam int STRAP_W  = 8;

  localparam logic [NUM_REGS-1:0][4:0] REG_DEV = {
    DEV_GFX, DEV_GFX, DEV_GFX, DEV_HOST, DEV_HOST, DEV_HOST, DEV_HOST, DEV_HOST};
  localparam logic [NUM_REGS-1:0][2:0] REG_FN = {
    FN_GFX, FN_GFX, FN_GFX, FN_VENDOR, FN_MEMIF, FN_LEGACY, FN_LEGACY, FN_LEGACY};
  // Dword index within the function (byte offset divided by four)
  localparam logic [NUM_REGS-1:0][5:0] REG_IDX = {
    6'h30, 6'h01, 6'h00, 6'h10, 6'h18, 6'h14, 6'h01, 6'h00};

  // ==========================================================================
  // Per-bit access attributes
  localparam logic [NUM_REGS-1:0][31:0] RO_MASK = {
    32'h0000_0000, 32'h0000_0000, 32'hffff_ffff, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'hffff_ffff};
  localparam logic [NUM_REGS-1:0][31:0] RW_MASK = {
    32'h0000_00ff, 32'h0000_ffff, 32'h0000_0000, 32'hffff_ffff,
    32'hffff_ffff, 32'h0000_0000, 32'h0000_ffff, 32'h0000_0000};
  localparam logic [NUM_REGS-1:0][31:0] W1C_MASK = {
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'hffff_0000, 32'h0000_0000};
  localparam logic [NUM_REGS-1:0][31:0] WO_MASK = {
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_00ff, 32'h0000_0000, 32'h0000_0000};
  localparam logic [NUM_REGS-1:0][31:0] LK_MASK = {
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_ff00, 32'h0000_0000, 32'h0000_0000};
  localparam logic [NUM_REGS-1:0][31:0] SET_MASK = {
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h8000_0000, 32'h0000_0000, 32'h0000_0000};

  // ==========================================================================
  // Reset values; identity words come from top-level parameters
  localparam logic [NUM_REGS-1:0][31:0] RST_VAL = {
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  // Read value of an unclaimed location
  localparam logic [31:0] RSVD_RDATA = 32'h0000_0000;

endpackage : csa_pkg
